// File: hw/pdc_pkg.sv
// Purpose: Shared constants and carriers for the pulse density and signaling control block.
// Assumes: One framer, one 40 MHz clock, 8-bit parallel control port.
// Notes:   Stream inputs arrive from pins and are synchronised in the top module.
package pdc_pkg;
  localparam logic [7:0] ADDR_SIG_CTRL   = 8'h11;
  localparam logic [7:0] ADDR_CRC_MON    = 8'h19;
  localparam logic [7:0] ADDR_CTRL_THREE = 8'h30;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h31;
  localparam logic [7:0] ADDR_MON_DATA   = 8'h32;
  localparam logic [7:0] RST_REG         = 8'h00;
  localparam logic [7:0] CRC_MON_WMASK   = 8'h9F;
  // Field positions of the signaling control register.
  localparam int SC_REINSERT   = 7;
  localparam int SC_RX_PERCHAN = 6;
  localparam int SC_FORCE_ONES = 5;
  localparam int SC_FREEZE_EN  = 4;
  localparam int SC_FORCE_FRZ  = 3;
  localparam int SC_TX_HW_SIG  = 2;
  localparam int SC_TX_PERCHAN = 1;
  localparam int SC_IDLE_FSEL  = 0;
  // Field positions of the other registers.
  localparam int CM_JAPAN_CRC  = 7;
  localparam int CM_SEL_MSB    = 4;
  localparam int CM_SEL_LSB    = 0;
  localparam int C3_DENSITY_EN = 3;
  localparam int ST_TX_VIOL    = 0;
  localparam int ST_RX_VIOL    = 1;
  // Density limits.
  localparam int MAX_ZEROS  = 15;
  localparam int WIN_MAX_N  = 23;
  localparam int WIN_UNIT   = 8;
  localparam int AGE_W      = 8;

  typedef struct packed {
    logic       valid;
    logic       ser;
    logic       sig_slot;
    logic       sig_bit;
    logic       chblk;
    logic       idle_mark;
    logic       rx_loop;
    logic [4:0] chan;
    logic [2:0] bit_idx;
  } pdc_tx_in_t;

  typedef struct packed {
    logic valid;
    logic ser;
    logic sig_slot;
    logic sig_bit;
    logic chblk;
    logic freeze_req;
  } pdc_rx_in_t;
endpackage

// File: hw/pdc_density_top.sv
// Purpose: Density checking and enforcing plus signaling, idle and monitor control of a framer.
// Assumes: Stream bit strobes are at most one per two clocks; CPU port is on SYS_CLK.
// Notes:   Stream pins pass two flip-flops; all stream outputs lag the synchronised bit by one.

module pdc_density_chk #(
  parameter int N_MAX = 23,
  parameter int UNIT  = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic bit_in,
  input  wire logic bit_valid,
  input  wire logic enforce,
  output logic      bit_out,
  output logic      out_valid,
  output logic      viol
);
  // Age of each of the last N_MAX ones, in bit times; saturates.
  logic [pdc_pkg::AGE_W-1:0] age      [N_MAX];
  logic [pdc_pkg::AGE_W-1:0] next_age [N_MAX];
  logic zero_bad;
  logic eff;
  logic next_bit_out;
  logic next_viol;

  function automatic logic [pdc_pkg::AGE_W-1:0] inc_sat(input logic [pdc_pkg::AGE_W-1:0] a);
    inc_sat = (&a) ? a : a + 8'h01;
  endfunction

  always_comb begin
    zero_bad = (age[0] >= 8'(pdc_pkg::MAX_ZEROS));
    for (int n = 0; n < N_MAX; n++) begin
      // A zero now would leave fewer than n+1 ones in the last 8*(n+2) bits.
      if (age[n] >= 8'(UNIT * (n + 2) - 1)) begin
        zero_bad = 1'b1;
      end
    end
    // Only a zero that would break a limit is turned into a one, at the last moment.
    eff = bit_in | (enforce & zero_bad);
    next_bit_out = bit_valid ? eff : bit_out;
    next_viol = bit_valid & ~bit_in & zero_bad;
    for (int n = 0; n < N_MAX; n++) begin
      next_age[n] = age[n];
      if (bit_valid) begin
        if (!eff) next_age[n] = inc_sat(age[n]);
        else if (n == 0) next_age[n] = 8'h00;
        else next_age[n] = inc_sat(age[n-1]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int n = 0; n < N_MAX; n++) age[n] <= 8'h00;
      bit_out   <= 1'b0;
      out_valid <= 1'b0;
      viol      <= 1'b0;
    end else begin
      age       <= next_age;
      bit_out   <= next_bit_out;
      out_valid <= bit_valid;
      viol      <= next_viol;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_zero_in;
    bit_valid && !bit_in;
  endsequence

  // Age of the oldest tracked one at which a further zero breaks the widest window.
  localparam logic [7:0] AGE_LAST = 8'(UNIT * (N_MAX + 1) - 1);

  AST_ZERO_RUN: assert property (s_zero_in ##0 (age[0] >= 8'(pdc_pkg::MAX_ZEROS)) |=> viol)
    else $error("zero run over 15 not flagged");
  AST_WINDOW_23: assert property (s_zero_in ##0 (age[N_MAX-1] >= AGE_LAST) |=> viol)
    else $error("sparse 192-bit window not flagged");
  AST_ENFORCE: assert property (bit_valid && enforce && zero_bad |=> bit_out && out_valid)
    else $error("enforcer did not force a one");
  AST_MIN_FORCE: assert property (s_zero_in ##0 !zero_bad |=> !bit_out && !viol)
    else $error("zero altered without need");
endmodule // pdc_density_chk

// How it works
// - Flag a run of more than fifteen zeros on either stream.
// - Flag any 8*(N+1)-bit window holding fewer than N ones, N from 1 to 23.
// - Transmit violations set status bit 0, receive violations set status bit 1.
// - With the enforcer enabled, the transmitted stream always meets both density limits.
// - Receive per-channel insert lets the receive block marker choose reinserted channels.
// - Receive force-ones drives every extracted signaling bit to one.
// - Freeze enable allows freezing on the signaling output and reinserted serial output.
// - Force freeze freezes receive signaling whatever the freeze enable says.
// - Transmit hardware signaling merges the signaling pin into transmit serial data.
// - Transmit per-channel insert limits pin signaling to channels the marker selects.
// - Idle function select: zero inserts idle code, one loops receive data back.
// - Transmit CRC select picks normal CRC6 at zero, Japanese CRC6 at one.
// - Five-bit select chooses the transmit channel copied into the monitor register.
// - Signaling control sits at 0x11, CRC and monitor control at 0x19, both 8 bits.
module pdc_density_top #(
  parameter logic [7:0] IDLE_CODE = 8'h7F
) (
  input  wire logic                SYS_CLK,
  input  wire logic                RST_N,
  input  wire logic [7:0]          ADDR,
  input  wire logic                WR_EN,
  input  wire logic                RD_EN,
  input  wire logic [7:0]          WDATA,
  output logic      [7:0]          RDATA,
  input  wire pdc_pkg::pdc_tx_in_t TX_IN,
  input  wire pdc_pkg::pdc_rx_in_t RX_IN,
  output logic                     TX_LINE_OUT,
  output logic                     TX_LINE_VALID,
  output logic                     RX_SER_OUT,
  output logic                     RX_SIG_OUT,
  output logic                     RX_OUT_VALID,
  output logic                     TX_CRC_JAPANESE
);
  pdc_pkg::pdc_tx_in_t tx_meta, tx_s;
  pdc_pkg::pdc_rx_in_t rx_meta, rx_s;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      tx_meta <= '0;
      tx_s    <= '0;
      rx_meta <= '0;
      rx_s    <= '0;
    end else begin
      tx_meta <= TX_IN;
      tx_s    <= tx_meta;
      rx_meta <= RX_IN;
      rx_s    <= rx_meta;
    end
  end

  // Registers and CPU port.
  logic [7:0] sig_ctrl, crc_mon, ctrl_three, status, mon_data;
  logic [7:0] next_sig_ctrl, next_crc_mon, next_ctrl_three, next_status, next_rdata;
  logic       tx_viol, rx_viol, st_read;

  always_comb begin
    next_sig_ctrl   = sig_ctrl;
    next_crc_mon    = crc_mon;
    next_ctrl_three = ctrl_three;
    if (WR_EN) begin
      case (ADDR)
        pdc_pkg::ADDR_SIG_CTRL:   next_sig_ctrl   = WDATA;
        pdc_pkg::ADDR_CRC_MON:    next_crc_mon    = WDATA & pdc_pkg::CRC_MON_WMASK;
        pdc_pkg::ADDR_CTRL_THREE: next_ctrl_three = WDATA;
        default:                  next_ctrl_three = ctrl_three;
      endcase
    end
    st_read = RD_EN && (ADDR == pdc_pkg::ADDR_STATUS_TWO);
    // A read clears the flags, but a violation in the same cycle wins.
    next_status = st_read ? 8'h00 : status;
    if (tx_viol) next_status[pdc_pkg::ST_TX_VIOL] = 1'b1;
    if (rx_viol) next_status[pdc_pkg::ST_RX_VIOL] = 1'b1;
    case (ADDR)
      pdc_pkg::ADDR_SIG_CTRL:   next_rdata = sig_ctrl;
      pdc_pkg::ADDR_CRC_MON:    next_rdata = crc_mon;
      pdc_pkg::ADDR_CTRL_THREE: next_rdata = ctrl_three;
      pdc_pkg::ADDR_STATUS_TWO: next_rdata = status;
      pdc_pkg::ADDR_MON_DATA:   next_rdata = mon_data;
      default:                  next_rdata = 8'h00;
    endcase
    if (!RD_EN) next_rdata = RDATA;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sig_ctrl   <= pdc_pkg::RST_REG;
      crc_mon    <= pdc_pkg::RST_REG;
      ctrl_three <= pdc_pkg::RST_REG;
      status     <= pdc_pkg::RST_REG;
      RDATA      <= 8'h00;
    end else begin
      sig_ctrl   <= next_sig_ctrl;
      crc_mon    <= next_crc_mon;
      ctrl_three <= next_ctrl_three;
      status     <= next_status;
      RDATA      <= next_rdata;
    end
  end

  assign TX_CRC_JAPANESE = crc_mon[pdc_pkg::CM_JAPAN_CRC];

  // Transmit path: idle or loopback, then pin signaling, then density enforcer.
  logic tx_bit, tx_sig_ins, tx_idle_bit;
  logic [7:0] mon_shift, next_mon_shift, next_mon_data;

  always_comb begin
    tx_idle_bit = sig_ctrl[pdc_pkg::SC_IDLE_FSEL] ? tx_s.rx_loop
                                                  : IDLE_CODE[3'h7 - tx_s.bit_idx];
    tx_bit = tx_s.idle_mark ? tx_idle_bit : tx_s.ser;
    tx_sig_ins = sig_ctrl[pdc_pkg::SC_TX_HW_SIG] && tx_s.sig_slot
                 && (!sig_ctrl[pdc_pkg::SC_TX_PERCHAN] || tx_s.chblk);
    if (tx_sig_ins) tx_bit = tx_s.sig_bit;
    next_mon_shift = mon_shift;
    next_mon_data  = mon_data;
    if (tx_s.valid && tx_s.chan == crc_mon[pdc_pkg::CM_SEL_MSB:pdc_pkg::CM_SEL_LSB]) begin
      next_mon_shift = {mon_shift[6:0], tx_bit};
      if (tx_s.bit_idx == 3'h7) next_mon_data = {mon_shift[6:0], tx_bit};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      mon_shift <= 8'h00;
      mon_data  <= 8'h00;
    end else begin
      mon_shift <= next_mon_shift;
      mon_data  <= next_mon_data;
    end
  end

  pdc_density_chk #(.N_MAX(pdc_pkg::WIN_MAX_N), .UNIT(pdc_pkg::WIN_UNIT)) u_tx_chk (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .bit_in    (tx_bit),
    .bit_valid (tx_s.valid),
    .enforce   (ctrl_three[pdc_pkg::C3_DENSITY_EN]),
    .bit_out   (TX_LINE_OUT),
    .out_valid (TX_LINE_VALID),
    .viol      (tx_viol)
  );

  pdc_density_chk #(.N_MAX(pdc_pkg::WIN_MAX_N), .UNIT(pdc_pkg::WIN_UNIT)) u_rx_chk (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .bit_in    (rx_s.ser),
    .bit_valid (rx_s.valid),
    .enforce   (1'b0),
    .bit_out   (),
    .out_valid (),
    .viol      (rx_viol)
  );

  // Receive signaling: force ones, freeze, reinsert.
  logic frozen, sig_val, sig_held, reinsert;
  logic next_sig_held, next_rx_ser, next_rx_sig;

  always_comb begin
    frozen = sig_ctrl[pdc_pkg::SC_FORCE_FRZ]
             || (sig_ctrl[pdc_pkg::SC_FREEZE_EN] && rx_s.freeze_req);
    sig_val = sig_ctrl[pdc_pkg::SC_FORCE_ONES] ? 1'b1
              : (frozen ? sig_held : rx_s.sig_bit);
    reinsert = sig_ctrl[pdc_pkg::SC_REINSERT] && rx_s.sig_slot
               && (!sig_ctrl[pdc_pkg::SC_RX_PERCHAN] || rx_s.chblk);
    next_sig_held = sig_held;
    next_rx_sig   = RX_SIG_OUT;
    next_rx_ser   = RX_SER_OUT;
    if (rx_s.valid) begin
      next_rx_ser = reinsert ? sig_val : rx_s.ser;
      if (rx_s.sig_slot) begin
        next_sig_held = sig_val;
        next_rx_sig   = sig_val;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sig_held     <= 1'b0;
      RX_SIG_OUT   <= 1'b0;
      RX_SER_OUT   <= 1'b0;
      RX_OUT_VALID <= 1'b0;
    end else begin
      sig_held     <= next_sig_held;
      RX_SIG_OUT   <= next_rx_sig;
      RX_SER_OUT   <= next_rx_ser;
      RX_OUT_VALID <= rx_s.valid;
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_rx_sig;
    rx_s.valid && rx_s.sig_slot;
  endsequence
  sequence s_write_sig;
    WR_EN && ADDR == pdc_pkg::ADDR_SIG_CTRL;
  endsequence

  AST_TX_FLAG: assert property (tx_viol |=> status[0])
    else $error("transmit violation not in status bit 0");
  AST_FLAG_HOLD: assert property (status[1] && !st_read |=> status[1])
    else $error("receive violation flag dropped without read");
  AST_FORCE_ONES: assert property (s_rx_sig ##0 sig_ctrl[5] |=> RX_SIG_OUT)
    else $error("forced signaling bit not one");
  AST_FORCE_FREEZE: assert property (s_rx_sig ##0 sig_ctrl[3] && !sig_ctrl[5]
                                     |=> RX_SIG_OUT == $past(sig_held))
    else $error("signaling changed while frozen");
  AST_TX_SIG_INS: assert property (tx_s.valid && tx_sig_ins && !ctrl_three[3]
                                   |=> TX_LINE_OUT == $past(tx_s.sig_bit))
    else $error("pin signaling not inserted");
  AST_REG_READ: assert property (s_write_sig ##1 (RD_EN && ADDR == 8'h11 && !WR_EN)
                                 |=> RDATA == $past(WDATA, 2))
    else $error("signaling control readback mismatch");
endmodule // pdc_density_top

// File: verif/pdc_line_model.sv
// Purpose: Far side model that sources the transmit and receive stream bits.
// Assumes: One bit strobe every six clocks, driven just after a rising edge.
// Notes:   Between strobes the data lines show inverted values, never a held bit.
module pdc_line_model (
  input  wire logic           clk,
  output pdc_pkg::pdc_tx_in_t tx_in,
  output pdc_pkg::pdc_rx_in_t rx_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    tx_in = '0;
    rx_in = '0;
  end

  // Strobes stay one cycle wide with five idle cycles between them.
  task automatic send(input pdc_pkg::pdc_tx_in_t t, input pdc_pkg::pdc_rx_in_t r);
    @(posedge clk);
    tx_in <= t;
    rx_in <= r;
    @(posedge clk);
    t.valid   = 1'b0;
    t.ser     = ~t.ser;
    t.sig_bit = ~t.sig_bit;
    t.rx_loop = ~t.rx_loop;
    r.valid   = 1'b0;
    r.ser     = ~r.ser;
    r.sig_bit = ~r.sig_bit;
    tx_in <= t;
    rx_in <= r;
    repeat (4) @(posedge clk);
  endtask
endmodule // pdc_line_model

// File: verif/pdc_density_top_test.sv
// Purpose: Self-checking bench for the density and signaling control block.
// Assumes: Stream bits come from the line model; registers via the CPU port.
// Notes:   Output bits are queued as they appear and compared in order.
module pdc_density_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] IDLE = 8'h7F;
  logic                clk   = 1'b0;
  logic                rst_n = 1'b0;
  logic [7:0]          addr  = 8'h00;
  logic                wr_en = 1'b0;
  logic                rd_en = 1'b0;
  logic [7:0]          wdata = 8'h00;
  logic [7:0]          rdata;
  logic [7:0]          d;
  logic                v;
  pdc_pkg::pdc_tx_in_t tx_in;
  pdc_pkg::pdc_rx_in_t rx_in;
  logic                tx_out, tx_vld, rx_ser, rx_sig, rx_vld, crc_jp;
  logic                tx_q[$];
  logic                ser_q[$];
  logic                sig_q[$];
  int                  error_cnt = 0;
  int                  samples_checked = 0;

  always #12.5 clk = ~clk;

  pdc_line_model line (.clk(clk), .tx_in(tx_in), .rx_in(rx_in));

  pdc_density_top #(.IDLE_CODE(IDLE)) DUT (
    .SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en),
    .WDATA(wdata), .RDATA(rdata), .TX_IN(tx_in), .RX_IN(rx_in),
    .TX_LINE_OUT(tx_out), .TX_LINE_VALID(tx_vld), .RX_SER_OUT(rx_ser),
    .RX_SIG_OUT(rx_sig), .RX_OUT_VALID(rx_vld), .TX_CRC_JAPANESE(crc_jp)
  );

  always @(posedge clk) begin
    if (tx_vld === 1'b1) tx_q.push_back(tx_out);
    if (rx_vld === 1'b1) begin
      ser_q.push_back(rx_ser);
      sig_q.push_back(rx_sig);
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk);
    addr  <= a;
    wdata <= w;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    #1 r = rdata;
  endtask

  // Waits a bounded time for an output bit; an empty queue ends the run.
  task automatic pop(ref logic q[$], output logic b);
    for (int n = 0; n < 40 && q.size() == 0; n++) @(posedge clk);
    if (q.size() == 0) begin
      check(8'h00, 8'h01);
      summarize();
    end else begin
      b = q.pop_front();
    end
  endtask

  task automatic txb(input logic s, slot, sb, blk, idl, lp, input logic [4:0] ch,
                     input logic [2:0] ix);
    pdc_pkg::pdc_tx_in_t t;
    t = '{1'b1, s, slot, sb, blk, idl, lp, ch, ix};
    line.send(t, '0);
  endtask

  task automatic rxb(input logic s, sb, blk, frz);
    pdc_pkg::pdc_rx_in_t r;
    r = '{1'b1, s, 1'b1, sb, blk, frz};
    line.send('0, r);
  endtask

  task automatic txn(input int n, input logic s);
    repeat (n) txb(s, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00, 3'h0);
  endtask

  task automatic t_regs();
    logic [7:0] map [5] = '{8'h11, 8'h19, 8'h30, 8'h31, 8'h32};
    foreach (map[i]) begin
      reg_rd(map[i], d);
      check(d, pdc_pkg::RST_REG);
    end
    reg_wr(8'h11, 8'hA5);
    reg_rd(8'h11, d);
    check(d, 8'hA5);
    // A read right behind a write must already return the new value.
    @(posedge clk);
    addr  <= 8'h11;
    wdata <= 8'h5A;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    check(rdata, 8'h5A);
    reg_wr(8'h19, 8'h83);
    reg_rd(8'h19, d);
    check(d, 8'h83);
    check({7'h0, crc_jp}, 8'h01);
    reg_wr(8'h19, 8'h00);
    reg_wr(8'h11, 8'h00);
    check({7'h0, crc_jp}, 8'h00);
    reg_wr(8'h20, 8'hFF);
    reg_rd(8'h20, d);
    check(d, 8'h00);
  endtask

  task automatic t_zero_run();
    tx_q.delete();
    txn(15, 1'b0);
    reg_rd(8'h31, d);
    check(d, 8'h00);
    txn(1, 1'b0);
    repeat (15) pop(tx_q, v);
    pop(tx_q, v);
    check({7'h0, v}, 8'h00);
    reg_rd(8'h31, d);
    check(d, 8'h01);
    reg_rd(8'h31, d);
    check(d, 8'h00);
  endtask

  task automatic t_window();
    txn(24, 1'b1);
    reg_rd(8'h31, d);
    repeat (6) begin
      txn(1, 1'b1);
      txn(7, 1'b0);
    end
    repeat (2) begin
      rxb(1'b1, 1'b0, 1'b0, 1'b0);
      repeat (15) rxb(1'b0, 1'b0, 1'b0, 1'b0);
    end
    reg_rd(8'h31, d);
    check(d, 8'h02);
  endtask

  // Ones every eight bits with two gaps 184 bits apart break only the 23-ones window.
  task automatic t_window23();
    txn(24, 1'b1);
    for (int c = 0; c < 24; c++) begin
      txn(1, c != 1);
      txn(7, 1'b0);
    end
    reg_rd(8'h31, d);
    check(d, 8'h00);
    txn(1, 1'b0);
    reg_rd(8'h31, d);
    check(d, 8'h01);
  endtask

  task automatic t_enforce();
    reg_wr(8'h30, 8'h08);
    txn(24, 1'b1);
    tx_q.delete();
    txn(16, 1'b0);
    for (int i = 0; i < 16; i++) begin
      pop(tx_q, v);
      check({7'h0, v}, {7'h0, i == 15});
    end
    reg_rd(8'h31, d);
    check(d, 8'h01);
    reg_wr(8'h30, 8'h00);
  endtask

  task automatic t_tx_sig();
    tx_q.delete();
    reg_wr(8'h11, 8'h06);
    for (int b = 0; b < 2; b++) begin
      txb(1'b0, 1'b1, 1'b1, b[0], 1'b0, 1'b0, 5'h01, 3'h7);
      pop(tx_q, v);
      check({7'h0, v}, b[7:0]);
    end
    reg_wr(8'h11, 8'h00);
    txb(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 5'h01, 3'h7);
    pop(tx_q, v);
    check({7'h0, v}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      txb(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 5'h02, i[2:0]);
      pop(tx_q, v);
      check({7'h0, v}, {7'h0, IDLE[7 - i]});
    end
    reg_wr(8'h11, 8'h01);
    txb(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 5'h02, 3'h0);
    pop(tx_q, v);
    check({7'h0, v}, 8'h01);
    reg_wr(8'h11, 8'h00);
  endtask

  task automatic rxs(input logic [7:0] c, input logic sb, blk, frz, es, eg);
    logic g;
    reg_wr(8'h11, c);
    rxb(1'b0, sb, blk, frz);
    pop(ser_q, v);
    pop(sig_q, g);
    check({6'h0, v, g}, {6'h0, es, eg});
  endtask

  task automatic t_rx_sig();
    ser_q.delete();
    sig_q.delete();
    rxs(8'h80, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    rxs(8'h88, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    rxs(8'h90, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rxs(8'h90, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    rxs(8'h00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    rxs(8'h20, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    rxs(8'hC0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    rxs(8'hC0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    reg_wr(8'h11, 8'h00);
  endtask

  task automatic t_monitor();
    logic [7:0] pat [2] = '{8'hA5, 8'h3C};
    reg_wr(8'h19, 8'h03);
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 8; i++) begin
        txb(pat[c][7 - i], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'(3 + c), i[2:0]);
      end
    end
    reg_rd(8'h32, d);
    check(d, 8'hA5);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_zero_run();
    t_window();
    t_window23();
    t_enforce();
    t_tx_sig();
    t_rx_sig();
    t_monitor();
    summarize();
  end
endmodule // pdc_density_top_test
